//--- verilog/iacc_cfg.svh
`ifndef IACC_CFG_SVH
`define IACC_CFG_SVH
// Management register offsets.
`define IACC_PTR_OFFSET 5'h10
`define IACC_DATA_OFFSET 5'h11
`define IACC_CTRL_OFFSET 5'h12
// Reset values.
`define IACC_PTR_RESET 16'h0000
`define IACC_DATA_RESET 16'h0000
`define IACC_CTRL_RESET 16'h0002
// Control register field positions.
`define IACC_AUTO_BIT 10
`define IACC_MANUAL_BIT 9
`define IACC_DIAG_BIT 2
`define IACC_RSVD_LO_MSB 1
// Writable bits of the control register.
`define IACC_CTRL_WMASK 16'h0607
`endif

//--- verilog/iacc_pkg.sv
package iacc_pkg;
    // Register access from station management.
    typedef struct packed {
        logic valid;
        logic write;
        logic [4:0] addr;
        logic [15:0] wdata;
    } iacc_mgmt_req_s;
    // Access to the extended register map.
    typedef struct packed {
        logic valid;
        logic write;
        logic [15:0] addr;
        logic [15:0] wdata;
    } iacc_ext_req_s;
    // Physical pair index for each logical pair.
    typedef struct packed {
        logic [1:0] pair3;
        logic [1:0] pair2;
        logic [1:0] pair1;
        logic [1:0] pair0;
    } iacc_pair_map_s;
    typedef enum logic [1:0] {
        IACC_MDI = 2'h1,
        IACC_MDIX = 2'h2
    } iacc_xover_e;
endpackage : iacc_pkg

//--- verilog/iacc_xover.sv
`timescale 1ns/100ps
// Resolves the crossover state and builds the pair map.
module iacc_xover (
    input wire logic ref_clk_in,
    input wire logic reset_in,
    input wire logic auto_en_in,
    input wire logic manual_sel_in,
    input wire logic auto_retry_in,
    output iacc_pkg::iacc_xover_e mode_out,
    output iacc_pkg::iacc_pair_map_s pair_map_out
);
    iacc_pkg::iacc_xover_e mode_reg;
    iacc_pkg::iacc_xover_e mode_next;
    iacc_pkg::iacc_xover_e pref;
    iacc_pkg::iacc_pair_map_s map_reg;
    iacc_pkg::iacc_pair_map_s map_next;

    // Preferred or forced configuration; in auto mode a retry flips the current choice.
    always_comb begin
        pref = manual_sel_in ? iacc_pkg::IACC_MDIX : iacc_pkg::IACC_MDI;
        mode_next = mode_reg;
        if (!auto_en_in) begin
            mode_next = pref;
        end else if (auto_retry_in) begin
            mode_next = (mode_reg == iacc_pkg::IACC_MDI) ? iacc_pkg::IACC_MDIX
                                                         : iacc_pkg::IACC_MDI;
        end
        case (mode_next)
            iacc_pkg::IACC_MDIX: begin
                map_next = '{pair3: 2'h3, pair2: 2'h2, pair1: 2'h1, pair0: 2'h0};
            end
            default: begin
                map_next = '{pair3: 2'h2, pair2: 2'h3, pair1: 2'h0, pair0: 2'h1};
            end
        endcase
    end

    // Registers the mode; reset loads MDI whatever the preferred configuration.
    always_ff @(posedge ref_clk_in) begin
        if (reset_in) begin
            mode_reg <= iacc_pkg::IACC_MDI;
            map_reg <= '{pair3: 2'h2, pair2: 2'h3, pair1: 2'h0, pair0: 2'h1};
        end else begin
            mode_reg <= mode_next;
            map_reg <= map_next;
        end
    end

    assign mode_out = mode_reg;
    assign pair_map_out = map_reg;
endmodule : iacc_xover

//--- verilog/iacc_regs.sv
// Notes on behaviour
// - A 16-bit read/write pointer at 0x10 holds the extended-map address for indirect access.
// - Reading the data window at 0x11 returns the pointed register and writing it updates that register.
// - Every extended-map register can also be reached directly, without pointer and window.
// - Reset clears the pointer and the data window to zero.
// - With auto crossover enabled, manual select is ignored: MDI after reset, then each retry flips the mode.
// - The reset value of the auto crossover enable bit comes from a strap pin.
// - Auto off and manual select set gives MDIX with pairs mapped straight through.
// - Auto off and manual select clear gives MDI with the pairs swapped.
// - The diagnostics clock runs only while the diagnostics clock enable bit is one.
// - The control register resets to 0x0002 with bit 10 taken from the strap, reserved bits 1:0 holding binary 10.
`timescale 1ns/100ps
`include "iacc_cfg.svh"
module iacc_regs (
    input wire logic ref_clk_in,
    input wire logic reset_in,
    input wire logic auto_strap_in,
    input iacc_pkg::iacc_mgmt_req_s mgmt_req_in,
    output logic [15:0] mgmt_rdata_out,
    output logic mgmt_rvalid_out,
    input iacc_pkg::iacc_ext_req_s direct_req_in,
    output logic direct_ready_out,
    output logic [15:0] direct_rdata_out,
    output logic direct_rvalid_out,
    output iacc_pkg::iacc_ext_req_s ext_req_out,
    input wire logic [15:0] ext_rdata_in,
    input wire logic auto_retry_in,
    output iacc_pkg::iacc_xover_e xover_mode_out,
    output iacc_pkg::iacc_pair_map_s pair_map_out,
    output logic diag_clk_out
);
    logic [15:0] ptr_reg;
    logic [15:0] ptr_next;
    logic [15:0] data_reg;
    logic [15:0] data_next;
    logic [15:0] ctrl_reg;
    logic [15:0] ctrl_next;
    logic [15:0] rdata_reg;
    logic [15:0] rdata_next;
    logic rvalid_reg;
    logic rvalid_next;
    logic [15:0] drdata_reg;
    logic [15:0] drdata_next;
    logic drvalid_reg;
    logic drvalid_next;
    logic diag_en_reg;
    logic window_hit;

    // A data window access owns the extended map port; direct access waits that cycle.
    always_comb begin
        window_hit = mgmt_req_in.valid && (mgmt_req_in.addr == `IACC_DATA_OFFSET);
        direct_ready_out = !window_hit;
        ext_req_out = '0;
        if (window_hit) begin
            ext_req_out.valid = 1'b1;
            ext_req_out.write = mgmt_req_in.write;
            ext_req_out.addr = ptr_reg;
            ext_req_out.wdata = mgmt_req_in.wdata;
        end else if (direct_req_in.valid) begin
            ext_req_out = direct_req_in;
        end
    end

    // Next state of the management registers and the read answer.
    always_comb begin
        ptr_next = ptr_reg;
        data_next = data_reg;
        ctrl_next = ctrl_reg;
        rdata_next = rdata_reg;
        rvalid_next = mgmt_req_in.valid && !mgmt_req_in.write;
        drvalid_next = direct_req_in.valid && !direct_req_in.write && !window_hit;
        drdata_next = drvalid_next ? ext_rdata_in : drdata_reg;
        if (mgmt_req_in.valid) begin
            case (mgmt_req_in.addr)
                `IACC_PTR_OFFSET: begin
                    if (mgmt_req_in.write) begin
                        ptr_next = mgmt_req_in.wdata;
                    end else begin
                        rdata_next = ptr_reg;
                    end
                end
                `IACC_DATA_OFFSET: begin
                    if (mgmt_req_in.write) begin
                        data_next = mgmt_req_in.wdata;
                    end else begin
                        data_next = ext_rdata_in;
                        rdata_next = ext_rdata_in;
                    end
                end
                `IACC_CTRL_OFFSET: begin
                    if (mgmt_req_in.write) begin
                        ctrl_next = mgmt_req_in.wdata & `IACC_CTRL_WMASK;
                    end else begin
                        rdata_next = ctrl_reg;
                    end
                end
                default: begin
                    rdata_next = 16'h0000;
                end
            endcase
        end
    end

    // Registers the state; the strap is caught while reset is held.
    always_ff @(posedge ref_clk_in) begin
        if (reset_in) begin
            ptr_reg <= `IACC_PTR_RESET;
            data_reg <= `IACC_DATA_RESET;
            ctrl_reg <= `IACC_CTRL_RESET;
            ctrl_reg[`IACC_AUTO_BIT] <= auto_strap_in;
            rdata_reg <= 16'h0000;
            rvalid_reg <= 1'b0;
            drdata_reg <= 16'h0000;
            drvalid_reg <= 1'b0;
        end else begin
            ptr_reg <= ptr_next;
            data_reg <= data_next;
            ctrl_reg <= ctrl_next;
            rdata_reg <= rdata_next;
            rvalid_reg <= rvalid_next;
            drdata_reg <= drdata_next;
            drvalid_reg <= drvalid_next;
        end
    end

    // Updates the clock gate enable on the falling edge so it holds stable while the clock is high, avoiding glitches.
    always_ff @(negedge ref_clk_in) begin
        diag_en_reg <= ctrl_reg[`IACC_DIAG_BIT] && !reset_in;
    end

    assign diag_clk_out = ref_clk_in & diag_en_reg;
    assign mgmt_rdata_out = rdata_reg;
    assign mgmt_rvalid_out = rvalid_reg;
    assign direct_rdata_out = drdata_reg;
    assign direct_rvalid_out = drvalid_reg;

    // Crossover resolution and pair mapping.
    iacc_xover u_xover (
        .ref_clk_in(ref_clk_in),
        .reset_in(reset_in),
        .auto_en_in(ctrl_reg[`IACC_AUTO_BIT]),
        .manual_sel_in(ctrl_reg[`IACC_MANUAL_BIT]),
        .auto_retry_in(auto_retry_in),
        .mode_out(xover_mode_out),
        .pair_map_out(pair_map_out)
    );
endmodule : iacc_regs

//--- bench/iacc_regs_assertions.sv
`timescale 1ns/100ps
// Checks read answers, window routing, direct access priority and pair maps.
module iacc_regs_assertions (
    input wire logic ref_clk_in,
    input wire logic reset_in,
    input iacc_pkg::iacc_mgmt_req_s mgmt_req_in,
    input logic [15:0] mgmt_rdata_out,
    input logic mgmt_rvalid_out,
    input iacc_pkg::iacc_ext_req_s direct_req_in,
    input logic direct_ready_out,
    input iacc_pkg::iacc_ext_req_s ext_req_out,
    input wire logic [15:0] ext_rdata_in,
    input iacc_pkg::iacc_xover_e xover_mode_out,
    input iacc_pkg::iacc_pair_map_s pair_map_out
);
    default clocking @(posedge ref_clk_in); endclocking
    default disable iff (reset_in);
    // Read requests and data window accesses seen this cycle.
    wire rd = mgmt_req_in.valid && !mgmt_req_in.write;
    wire win = mgmt_req_in.valid && mgmt_req_in.addr == 5'h11;
    AST_RD_ANSWER: assert property (rd |=> mgmt_rvalid_out)
        else $error("read not answered");
    AST_NO_SPURIOUS: assert property (!rd |=> !mgmt_rvalid_out)
        else $error("spurious read answer");
    AST_PTR_TARGET: assert property (mgmt_req_in.valid && mgmt_req_in.write &&
        mgmt_req_in.addr == 5'h10 ##1 win |-> ext_req_out.valid &&
        ext_req_out.addr == $past(mgmt_req_in.wdata)) else $error("window misses pointer");
    AST_WIN_DATA: assert property (rd && win |=> mgmt_rdata_out == $past(ext_rdata_in))
        else $error("window read data wrong");
    AST_DIRECT_HOLD: assert property (win |-> !direct_ready_out)
        else $error("direct access not held off");
    AST_DIRECT_PASS: assert property (direct_req_in.valid && direct_ready_out |->
        ext_req_out.valid && ext_req_out.addr == direct_req_in.addr) else $error("direct lost");
    AST_MDIX_MAP: assert property (xover_mode_out == iacc_pkg::IACC_MDIX |->
        pair_map_out == 8'hE4) else $error("straight map wrong");
    AST_MDI_MAP: assert property (xover_mode_out == iacc_pkg::IACC_MDI |->
        pair_map_out == 8'hB1) else $error("swapped map wrong");
endmodule : iacc_regs_assertions
bind iacc_regs iacc_regs_assertions u_iacc_regs_assertions (.ref_clk_in(ref_clk_in),
    .reset_in(reset_in), .mgmt_req_in(mgmt_req_in), .mgmt_rdata_out(mgmt_rdata_out),
    .mgmt_rvalid_out(mgmt_rvalid_out), .direct_req_in(direct_req_in),
    .direct_ready_out(direct_ready_out), .ext_req_out(ext_req_out), .ext_rdata_in(ext_rdata_in),
    .xover_mode_out(xover_mode_out), .pair_map_out(pair_map_out));

//--- bench/iacc_ext_map_model.sv
`timescale 1ns/100ps
// Extended register map: answers reads at once and stores writes on the edge.
module iacc_ext_map_model (
    input wire logic ref_clk_in,
    input iacc_pkg::iacc_ext_req_s ext_req_in,
    output logic [15:0] ext_rdata_out
);
    logic [15:0] mem [256] = '{default: 16'h0000};
    // Without a request the data is inverted so a stale read cannot pass.
    assign ext_rdata_out = ext_req_in.valid ? mem[ext_req_in.addr[7:0]] :
        ~mem[ext_req_in.addr[7:0]];
    // Writes land on the rising edge.
    always @(posedge ref_clk_in) if (ext_req_in.valid && ext_req_in.write)
        mem[ext_req_in.addr[7:0]] <= ext_req_in.wdata;
endmodule : iacc_ext_map_model

//--- bench/testbench.sv
`timescale 1ns/100ps
module testbench;
    logic ref_clk_in = 0;
    logic reset_in = 1;
    logic auto_retry_in = 0;
    iacc_pkg::iacc_mgmt_req_s mgmt = '0;
    iacc_pkg::iacc_ext_req_s direct = '0;
    iacc_pkg::iacc_ext_req_s ext_req;
    iacc_pkg::iacc_xover_e mode;
    iacc_pkg::iacc_pair_map_s map;
    logic [15:0] rdata, ext_rdata, a, d;
    logic rvalid, diag_clk, drvalid;
    logic [15:0] drdata;
    logic [31:0] seed = 32'h27B18E6C;
    logic [15:0] exp_q [$];
    int mismatches = 0;
    int compares = 0;
    int diag_edges = 0;
    localparam logic [15:0] XV [3] = '{16'h0202, 16'h0002, 16'h0402};
    localparam logic [15:0] XM [3] = '{16'h0002, 16'h0001, 16'h0002};
    localparam logic [15:0] XP [3] = '{16'h00E4, 16'h00B1, 16'h00E4};
    iacc_regs u_iacc_regs (.ref_clk_in(ref_clk_in), .reset_in(reset_in), .auto_strap_in(1'b1),
        .mgmt_req_in(mgmt), .mgmt_rdata_out(rdata), .mgmt_rvalid_out(rvalid),
        .direct_req_in(direct), .direct_ready_out(), .direct_rdata_out(drdata),
        .direct_rvalid_out(drvalid),
        .ext_req_out(ext_req), .ext_rdata_in(ext_rdata), .auto_retry_in(auto_retry_in),
        .xover_mode_out(mode), .pair_map_out(map), .diag_clk_out(diag_clk));
    iacc_ext_map_model u_iacc_ext_map_model (.ref_clk_in(ref_clk_in), .ext_req_in(ext_req),
        .ext_rdata_out(ext_rdata));
    // Clock of 50 ns period.
    always #25 ref_clk_in = ~ref_clk_in;
    // Counts diagnostics clock edges.
    always @(posedge diag_clk) diag_edges++;
    // Compares each read answer with the oldest expectation.
    always @(negedge ref_clk_in) if (rvalid === 1'b1) check(rdata, exp_q.pop_front(), "rdata");
    // Compares each direct read answer with the oldest expectation.
    always @(negedge ref_clk_in) if (drvalid === 1'b1) check(drdata, exp_q.pop_front(), "drdata");
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr
    task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
        compares++;
        if (seen !== exp) begin
            mismatches++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    // Issues one access and leaves valid high; a read notes its expected data.
    task automatic acc(input logic w, input logic [4:0] ad, input logic [15:0] v);
        if (!w) exp_q.push_back(v);
        mgmt = '{1'b1, w, ad, v};
        @(negedge ref_clk_in);
    endtask : acc
    task automatic idle();
        mgmt.valid = 0;
        @(negedge ref_clk_in);
    endtask : idle
    task automatic end_sim();
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : end_sim
    // Main sequence.
    initial begin
        repeat (12) @(negedge ref_clk_in);
        reset_in = 0;
        // The gated clock is unknown before the first falling clock edge; count only from here.
        diag_edges = 0;
        acc(0, 5'h10, 16'h0000);
        acc(0, 5'h11, 16'h0000);
        acc(0, 5'h12, 16'h0402);
        acc(0, 5'h05, 16'h0000);
        idle();
        $display("test reset done");
        repeat (4) begin
            seed = lfsr(seed);
            a = seed[15:0] & 16'h00FF;
            d = seed[31:16];
            acc(1, 5'h10, a);
            acc(1, 5'h11, d);
            acc(0, 5'h11, d);
            acc(0, 5'h10, a);
            idle();
        end
        direct = '{1'b1, 1'b1, a ^ 16'h0001, ~d};
        @(negedge ref_clk_in);
        direct.valid = 0;
        acc(1, 5'h10, a ^ 16'h0001);
        acc(0, 5'h11, ~d);
        idle();
        // Direct read of the same register, answered on the direct port.
        exp_q.push_back(~d);
        direct = '{1'b1, 1'b0, a ^ 16'h0001, 16'h0000};
        @(negedge ref_clk_in);
        direct.valid = 0;
        @(negedge ref_clk_in);
        $display("test indirect done");
        check(16'(diag_edges), 16'h0000, "diag off");
        acc(1, 5'h12, 16'hFFFF);
        acc(0, 5'h12, 16'h0607);
        idle();
        check(16'(diag_edges > 0), 16'h0001, "diag on");
        $display("test control done");
        foreach (XV[i]) begin
            acc(1, 5'h12, XV[i]);
            idle();
            auto_retry_in = 1;
            @(negedge ref_clk_in);
            auto_retry_in = 0;
            repeat (2) @(negedge ref_clk_in);
            check({14'h0000, mode}, XM[i], "mode");
            check({8'h00, map}, XP[i], "pair map");
        end
        diag_edges = 0;
        repeat (5) @(negedge ref_clk_in);
        check(16'(diag_edges), 16'h0000, "diag stopped");
        check(16'(exp_q.size()), 16'h0000, "answers left");
        $display("test crossover done");
        end_sim();
    end
    // Cuts a hang short.
    initial begin
        #100000;
        mismatches++;
        end_sim();
    end
endmodule : testbench
